/* File: rtl/adc_output_mode_test_pattern_regs.sv */
// output-mode and test-pattern registers with serial port and output mux
`timescale 1ns/1ns
module adc_output_mode_test_pattern_regs
(
  // system clock and reset
  input  wire logic                             clock_i,
  input  wire logic                             srst_i,
  // serial configuration port
  input  wire logic                             sck_i,
  input  wire logic                             cs_n_i,
  input  wire logic                             sdi_i,
  output logic                                  sdo_o,
  output logic                                  sdo_oe_o,
  // sample path
  input  wire logic [adc_regs_pkg::SAMPLE_W-1:0] sample_i,
  input  wire logic                             twos_comp_i,
  input  wire logic                             randomize_i,
  output logic      [adc_regs_pkg::OUT_W-1:0]   out_data_o,
  // output-mode fields and the test-pattern enable
  output logic      [2:0]                       driver_current_sel_o,
  output logic                                  internal_term_en_o,
  output logic                                  output_disable_o,
  output logic      [2:0]                       lane_serial_mode_o,
  output logic                                  test_pattern_en_o,
  // decoded driver settings
  output logic      [adc_regs_pkg::CURR_W-1:0]  drive_current_o,
  output logic                                  current_code_valid_o,
  output logic      [1:0]                       lane_count_o,
  output logic      [4:0]                       serial_bits_o,
  output logic                                  lane_mode_valid_o,
  // driver enables
  output logic                                  lane_drive_en_o,
  output logic                                  data_clock_out_en_o,
  output logic                                  frame_out_en_o
);

  import adc_regs_pkg::*;

  // mode-control registers, system clock domain
  logic [7:0]          output_mode_r;
  logic [7:0]          test_pattern_high_r;
  logic [7:0]          test_pattern_low_r;

  // serial clock domain
  logic [CNT_W-1:0]    bit_cnt_r;
  logic [WORD_BITS-1:0] shift_r;
  logic [WORD_BITS-1:0] word_r;
  logic                done_tgl_r;
  logic [7:0]          rd_shift_r;
  logic                rd_active_r;
  logic [7:0]          read_byte;

  // system side of the frame handshake
  logic                done_sync;
  logic                done_seen_r;
  logic                word_stb;
  logic                wr_stb;
  logic [6:0]          wr_addr;
  logic [7:0]          wr_data;
  logic                swrst;

  // output path
  logic [SAMPLE_W-1:0] fmt_sample;
  logic [OUT_W-1:0]    out_data_r;
  logic [CURR_W-1:0]   drive_current_r;
  logic                current_valid_r;
  logic [1:0]          lane_count_r;
  logic [4:0]          serial_bits_r;
  logic                lane_valid_r;
  logic                drive_en_r;

  // bit counter: cleared whenever chip select is high, stops at 16
  always_ff @(posedge sck_i or posedge cs_n_i or posedge srst_i)
  begin
    if (cs_n_i || srst_i)
      bit_cnt_r <= '0;
    else if (bit_cnt_r != CNT_FULL)
      bit_cnt_r <= bit_cnt_r + 5'h01;
  end

  // input shifter: edges after the sixteenth are ignored
  always_ff @(posedge sck_i)
  begin
    if (bit_cnt_r != CNT_FULL)
      shift_r <= {shift_r[WORD_BITS-2:0], sdi_i};
  end

  // capture the finished word and announce it by a toggle
  always_ff @(posedge sck_i or posedge srst_i)
  begin
    if (srst_i)
    begin
      word_r     <= '0;
      done_tgl_r <= 1'b0;
    end
    else if (bit_cnt_r == CNT_LAST)
    begin
      word_r     <= {shift_r[WORD_BITS-2:0], sdi_i};
      done_tgl_r <= ~done_tgl_r;
    end
  end

  // readback source; registers only change between frames, so the
  // value is stable while the serial side samples it
  always_comb
  begin
    case (shift_r[6:0])
      ADDR_OUT:     read_byte = output_mode_r;
      ADDR_TP_HIGH: read_byte = test_pattern_high_r;
      ADDR_TP_LOW:  read_byte = test_pattern_low_r;
      default:      read_byte = REG_RESET;
    endcase
  end

  // readback shifter on the falling edge, open-drain drive of sdo
  always_ff @(negedge sck_i or posedge cs_n_i or posedge srst_i)
  begin
    if (cs_n_i || srst_i)
    begin
      rd_shift_r  <= '0;
      rd_active_r <= 1'b0;
    end
    else if (bit_cnt_r == CNT_ADDR_END)
    begin
      rd_shift_r  <= read_byte;
      rd_active_r <= shift_r[7];
    end
    else if (bit_cnt_r == CNT_FULL)
      rd_active_r <= 1'b0;
    else
      rd_shift_r  <= {rd_shift_r[6:0], 1'b0};
  end

  assign sdo_o    = 1'b0;
  assign sdo_oe_o = rd_active_r & ~rd_shift_r[7];

  // bring the frame toggle into the system domain
  bit_sync u_done_sync
  (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .d_i     (done_tgl_r),
    .q_o     (done_sync)
  );

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      done_seen_r <= 1'b0;
    else
      done_seen_r <= done_sync;
  end

  assign word_stb = done_sync ^ done_seen_r;
  assign wr_stb   = word_stb & ~word_r[RW_BIT];
  assign wr_addr  = word_r[ADDR_MSB:ADDR_LSB];
  assign wr_data  = word_r[DATA_MSB:0];
  assign swrst    = wr_stb && (wr_addr == ADDR_RESET)
                    && wr_data[SWRST_BIT];

  // output-mode register
  always_ff @(posedge clock_i)
  begin
    if (srst_i || swrst)
      output_mode_r <= REG_RESET;
    else if (wr_stb && wr_addr == ADDR_OUT)
      output_mode_r <= wr_data;
  end

  // test-pattern high register; the unused bit is never stored
  always_ff @(posedge clock_i)
  begin
    if (srst_i || swrst)
      test_pattern_high_r <= REG_RESET;
    else if (wr_stb && wr_addr == ADDR_TP_HIGH)
    begin
      test_pattern_high_r             <= wr_data;
      test_pattern_high_r[TP_NOP_BIT] <= 1'b0;
    end
  end

  // test-pattern low register
  always_ff @(posedge clock_i)
  begin
    if (srst_i || swrst)
      test_pattern_low_r <= REG_RESET;
    else if (wr_stb && wr_addr == ADDR_TP_LOW)
      test_pattern_low_r <= wr_data;
  end

  // raw fields straight from the output-mode register, and the enable bit from the test-pattern high register
  assign driver_current_sel_o = output_mode_r[CUR_MSB:CUR_LSB];
  assign internal_term_en_o   = output_mode_r[TERM_BIT];
  assign output_disable_o     = output_mode_r[OFF_BIT];
  assign lane_serial_mode_o   = output_mode_r[MODE_MSB:0];
  assign test_pattern_en_o    = test_pattern_high_r[TP_EN_BIT];

  // driver current decode, doubled when termination is on
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      drive_current_r <= CURR_3M5;
      current_valid_r <= 1'b1;
    end
    else
    begin
      current_valid_r <= 1'b1;
      case (output_mode_r[CUR_MSB:CUR_LSB])
        3'h0:    drive_current_r <= CURR_3M5;
        3'h1:    drive_current_r <= CURR_4M0;
        3'h2:    drive_current_r <= CURR_4M5;
        3'h4:    drive_current_r <= CURR_3M0;
        3'h5:    drive_current_r <= CURR_2M5;
        3'h6:    drive_current_r <= CURR_2M1;
        3'h7:    drive_current_r <= CURR_1M75;
        default:
        begin
          drive_current_r <= CURR_NONE;
          current_valid_r <= 1'b0;
        end
      endcase
      if (output_mode_r[TERM_BIT])
      begin
        case (output_mode_r[CUR_MSB:CUR_LSB])
          3'h0:    drive_current_r <= CURR_3M5 << 1;
          3'h1:    drive_current_r <= CURR_4M0 << 1;
          3'h2:    drive_current_r <= CURR_4M5 << 1;
          3'h4:    drive_current_r <= CURR_3M0 << 1;
          3'h5:    drive_current_r <= CURR_2M5 << 1;
          3'h6:    drive_current_r <= CURR_2M1 << 1;
          3'h7:    drive_current_r <= CURR_1M75 << 1;
          default: drive_current_r <= CURR_NONE;
        endcase
      end
    end
  end

  // lane count and serialization length decode
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      lane_count_r  <= LANES_TWO;
      serial_bits_r <= SER_16;
      lane_valid_r  <= 1'b1;
    end
    else
    begin
      lane_valid_r <= 1'b1;
      case (output_mode_r[MODE_MSB:0])
        3'h0:
        begin
          lane_count_r  <= LANES_TWO;
          serial_bits_r <= SER_16;
        end
        3'h1:
        begin
          lane_count_r  <= LANES_TWO;
          serial_bits_r <= SER_14;
        end
        3'h2:
        begin
          lane_count_r  <= LANES_TWO;
          serial_bits_r <= SER_12;
        end
        3'h5:
        begin
          lane_count_r  <= LANES_ONE;
          serial_bits_r <= SER_14;
        end
        3'h6:
        begin
          lane_count_r  <= LANES_ONE;
          serial_bits_r <= SER_12;
        end
        3'h7:
        begin
          lane_count_r  <= LANES_ONE;
          serial_bits_r <= SER_16;
        end
        default:
        begin
          lane_count_r  <= LANES_NONE;
          serial_bits_r <= SER_NONE;
          lane_valid_r  <= 1'b0;
        end
      endcase
    end
  end

  // one disable bit gates lanes, data clock and frame together
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      drive_en_r <= 1'b1;
    else
      drive_en_r <= ~output_mode_r[OFF_BIT];
  end

  assign lane_drive_en_o      = drive_en_r;
  assign data_clock_out_en_o  = drive_en_r;
  assign frame_out_en_o       = drive_en_r;

  // normal formatting: two's complement flips the msb, the randomizer
  // xors the lsb into all the other bits
  always_comb
  begin
    fmt_sample = sample_i;
    if (twos_comp_i)
      fmt_sample[SAMPLE_W-1] = ~fmt_sample[SAMPLE_W-1];
    if (randomize_i)
      fmt_sample[SAMPLE_W-1:1] = fmt_sample[SAMPLE_W-1:1]
                                 ^ {(SAMPLE_W-1){fmt_sample[0]}};
  end

  // the test pattern wins over every formatting option
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      out_data_r <= '0;
    else if (test_pattern_high_r[TP_EN_BIT])
      out_data_r <= {test_pattern_high_r[TP_UP_MSB:0],
                     test_pattern_low_r[TP_LO_MSB:TP_LO_LSB],
                     test_pattern_low_r[TP_XY_MSB:0]};
    else
      out_data_r <= {fmt_sample, 2'h0};
  end

  assign out_data_o           = out_data_r;
  assign drive_current_o      = drive_current_r;
  assign current_code_valid_o = current_valid_r;
  assign lane_count_o         = lane_count_r;
  assign serial_bits_o        = serial_bits_r;
  assign lane_mode_valid_o    = lane_valid_r;

endmodule

/* File: rtl/adc_regs_pkg.sv */
// constants for the output-mode and test-pattern register bank
// Notes on behaviour
// - Bits 7:5 of the output-mode register pick the driver current: 000=3.5, 001=4.0, 010=4.5, 100=3.0, 101=2.5, 110=2.1, 111=1.75 mA, and 011 is unused.
// - Bit 4 of the output-mode register turns internal termination on and doubles the selected driver current; clear means termination off.
// - Bit 3 of the output-mode register disables the digital outputs when set and keeps them enabled when clear.
// - Bits 2:0 of the output-mode register pick lanes and serialization: 000/001/010 two lanes at 16/14/12 bits, 101/110/111 one lane at 14/12/16 bits, 011 and 100 unused.
// - Bit 7 of the test-pattern high register at 03h turns the output test pattern on.
// - Bits 5:0 of the test-pattern high register force output data bits 11 down to 6.
// - Bit 6 of the test-pattern high register has no function and its written value is ignored.
// - Bits 7:2 of the test-pattern low register at 04h force output data bits 5 down to 0.
// - Bits 1:0 of the test-pattern low register force the two extra compatibility output bits.
// - Current, termination, disable and mode fields all sit in the output-mode register at 02h.
// - An enabled test pattern overrides every other output formatting, two's complement and randomizer included.
// - Each access is a 16-bit serial word: read flag, seven address bits, eight data bits; a set flag reads instead of writes.
// - Output disable also removes drive from the data clock output and the frame output.
// - A software reset clears every mode-control register to 00h.
package adc_regs_pkg;

  // serial word layout
  localparam int          WORD_BITS    = 16;
  localparam int          CNT_W        = 5;
  localparam logic [4:0]  CNT_ADDR_END = 5'h08;
  localparam logic [4:0]  CNT_LAST     = 5'h0f;
  localparam logic [4:0]  CNT_FULL     = 5'h10;
  localparam int          RW_BIT       = 15;
  localparam int          ADDR_MSB     = 14;
  localparam int          ADDR_LSB     = 8;
  localparam int          DATA_MSB     = 7;

  // register addresses
  localparam logic [6:0]  ADDR_RESET   = 7'h00;
  localparam logic [6:0]  ADDR_OUT     = 7'h02;
  localparam logic [6:0]  ADDR_TP_HIGH = 7'h03;
  localparam logic [6:0]  ADDR_TP_LOW  = 7'h04;
  localparam logic [7:0]  REG_RESET    = 8'h00;

  // field positions
  localparam int          SWRST_BIT    = 7;
  localparam int          CUR_MSB      = 7;
  localparam int          CUR_LSB      = 5;
  localparam int          TERM_BIT     = 4;
  localparam int          OFF_BIT      = 3;
  localparam int          MODE_MSB     = 2;
  localparam int          TP_EN_BIT    = 7;
  localparam int          TP_NOP_BIT   = 6;
  localparam int          TP_UP_MSB    = 5;
  localparam int          TP_LO_MSB    = 7;
  localparam int          TP_LO_LSB    = 2;
  localparam int          TP_XY_MSB    = 1;

  // sample path widths
  localparam int          SAMPLE_W     = 12;
  localparam int          OUT_W        = 14;

  // driver current, in units of 10 uA
  localparam int          CURR_W       = 10;
  localparam logic [9:0]  CURR_3M5     = 10'h15e;
  localparam logic [9:0]  CURR_4M0     = 10'h190;
  localparam logic [9:0]  CURR_4M5     = 10'h1c2;
  localparam logic [9:0]  CURR_3M0     = 10'h12c;
  localparam logic [9:0]  CURR_2M5     = 10'h0fa;
  localparam logic [9:0]  CURR_2M1     = 10'h0d2;
  localparam logic [9:0]  CURR_1M75    = 10'h0af;
  localparam logic [9:0]  CURR_NONE    = 10'h000;

  // lane and serialization decode
  localparam logic [1:0]  LANES_NONE   = 2'h0;
  localparam logic [1:0]  LANES_ONE    = 2'h1;
  localparam logic [1:0]  LANES_TWO    = 2'h2;
  localparam logic [4:0]  SER_NONE     = 5'h00;
  localparam logic [4:0]  SER_12       = 5'h0c;
  localparam logic [4:0]  SER_14       = 5'h0e;
  localparam logic [4:0]  SER_16       = 5'h10;

endpackage

/* File: rtl/bit_sync.sv */
// two flip-flop synchroniser for one level
`timescale 1ns/1ns
module bit_sync
(
  // destination clock and reset
  input  wire logic clock_i,
  input  wire logic srst_i,
  // level in and synchronised level out
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_r;
  logic sync_r;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;

endmodule

/* File: test/adc_regs_monitor.sv */
// concurrent checks on the register bank ports
`timescale 1ns/1ns
module adc_regs_monitor
  import adc_regs_pkg::*;
(
  // clock and reset
  input wire logic        clock_i,
  input wire logic        srst_i,
  // serial and sample inputs
  input wire logic        cs_n_i,
  input wire logic [11:0] sample_i,
  input wire logic        twos_comp_i,
  input wire logic        randomize_i,
  // observed outputs
  input wire logic        sdo_oe_o,
  input wire logic [13:0] out_data_o,
  input wire logic [2:0]  driver_current_sel_o,
  input wire logic        internal_term_en_o,
  input wire logic        output_disable_o,
  input wire logic [2:0]  lane_serial_mode_o,
  input wire logic        test_pattern_en_o,
  input wire logic [9:0]  drive_current_o,
  input wire logic        current_code_valid_o,
  input wire logic [1:0]  lane_count_o,
  input wire logic [4:0]  serial_bits_o,
  input wire logic        lane_mode_valid_o,
  input wire logic        lane_drive_en_o,
  input wire logic        data_clock_out_en_o,
  input wire logic        frame_out_en_o
);
  localparam logic [9:0] CUR_T [8] = '{CURR_3M5, CURR_4M0, CURR_4M5,
    CURR_NONE, CURR_3M0, CURR_2M5, CURR_2M1, CURR_1M75};
  localparam logic [6:0] LN_T [8] = '{7'h50, 7'h4e, 7'h4c, 7'h00,
    7'h00, 7'h2e, 7'h2c, 7'h30};
  logic [9:0]  cur_exp;
  logic [6:0]  lane_exp;
  logic [11:0] fmt;
  logic [3:0]  cs_hi_cnt;
  assign cur_exp = CUR_T[driver_current_sel_o] << internal_term_en_o;
  assign lane_exp = LN_T[lane_serial_mode_o];
  assign fmt = sample_i ^ {twos_comp_i, 11'h000}
             ^ {{11{randomize_i & sample_i[0]}}, 1'b0};
  // cycles since chip select went high; a write lands within four, so
  // past eight the pattern registers cannot move
  always_ff @(posedge clock_i)
  begin
    if (srst_i || !cs_n_i)
      cs_hi_cnt <= 4'h0;
    else if (cs_hi_cnt != 4'hf)
      cs_hi_cnt <= cs_hi_cnt + 4'h1;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  sequence pat_held;
    (test_pattern_en_o && cs_hi_cnt > 4'h7) ##1 test_pattern_en_o;
  endsequence
  cur_valid_a: assert property (
    current_code_valid_o == ($past(driver_current_sel_o) != 3'h3))
    else $error("current valid flag wrong");
  cur_decode_a: assert property (
    drive_current_o == $past(cur_exp))
    else $error("driver current decode wrong");
  lane_decode_a: assert property (
    {lane_count_o, serial_bits_o} == $past(lane_exp))
    else $error("lane decode wrong");
  lane_valid_a: assert property (
    lane_mode_valid_o == (lane_count_o != 2'h0))
    else $error("lane valid flag wrong");
  drive_off_a: assert property (
    lane_drive_en_o == !$past(output_disable_o))
    else $error("lane drive enable wrong");
  clk_frame_off_a: assert property (
    {data_clock_out_en_o, frame_out_en_o} == {2{lane_drive_en_o}})
    else $error("clock or frame enable wrong");
  pattern_hold_a: assert property (
    pat_held |=> $stable(out_data_o))
    else $error("output moved under test pattern");
  sample_path_a: assert property (
    !$past(srst_i) && !$past(test_pattern_en_o)
    |-> out_data_o == {$past(fmt), 2'b00})
    else $error("formatted sample wrong");
  sdo_idle_a: assert property (
    cs_n_i |-> !sdo_oe_o)
    else $error("sdo driven outside frame");
endmodule
bind adc_output_mode_test_pattern_regs adc_regs_monitor adc_regs_monitor_i (.*);

/* File: test/serial_host.sv */
// serial configuration host model for the register port
`timescale 1ns/1ns
module serial_host
(
  // serial port; sdo_i is the resolved wire level
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  initial
  begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b1;
  end
  // one word per frame, msb first; clock idles low between frames;
  // n counts the clock edges, so a frame may be cut short or run long
  // and edges past the word carry ones
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [7:0] rd);
    int k;
    rd = 8'h00;
    // start off the system clock edges; a whole 16-edge call spans 108 periods
    #3;
    cs_n_o = 1'b0;
    for (k = 15; k > 15 - n; k--)
    begin
      sdi_o = (k >= 0) ? w[k[3:0]] : 1'b1;
      #24 sck_o = 1'b1;
      if (k < 8 && k >= 0)
        rd[k[2:0]] = sdo_i;
      #24 sck_o = 1'b0;
    end
    #24 cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    #69;
  endtask
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the output-mode and test-pattern registers
`timescale 1ns/1ns
module tb_top;
  import adc_regs_pkg::*;
  logic        clock_i     = 1'b0;
  logic        srst_i      = 1'b1;
  logic [11:0] sample_i    = 12'h000;
  logic        twos_comp_i = 1'b0;
  logic        randomize_i = 1'b0;
  logic        sck, cs_n, sdi, sdo, sdo_oe;
  logic [13:0] out_data;
  logic [2:0]  cur_sel, mode;
  logic        term, off, tp_en, cur_ok, mode_ok, lane_en, dco_en, fr_en;
  logic [9:0]  drive;
  logic [1:0]  lanes;
  logic [4:0]  bits;
  logic [7:0]  rd;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc       = 0;
  // rows: {data, 2'b0, current, 1'b0, lanes, bits}; terminated rows
  // use only the low current settings
  logic [27:0] rows [8] = '{28'h00_15e_50, 28'h29_190_4e, 28'h42_1c2_4c,
    28'h63_000_00, 28'h8c_12c_00, 28'hb5_1f4_2e, 28'hde_1a4_2c,
    28'hf7_15e_30};
  // open-drain line with pull-up
  wire sdo_w = sdo_oe ? sdo : 1'b1;
  adc_output_mode_test_pattern_regs adc_output_mode_test_pattern_regs_i (
    .clock_i(clock_i), .srst_i(srst_i), .sck_i(sck), .cs_n_i(cs_n),
    .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .sample_i(sample_i),
    .twos_comp_i(twos_comp_i), .randomize_i(randomize_i),
    .out_data_o(out_data), .driver_current_sel_o(cur_sel),
    .internal_term_en_o(term), .output_disable_o(off),
    .lane_serial_mode_o(mode), .test_pattern_en_o(tp_en),
    .drive_current_o(drive), .current_code_valid_o(cur_ok),
    .lane_count_o(lanes), .serial_bits_o(bits),
    .lane_mode_valid_o(mode_ok), .lane_drive_en_o(lane_en),
    .data_clock_out_en_o(dco_en), .frame_out_en_o(fr_en));
  serial_host serial_host_i (.sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi),
    .sdo_i(sdo_w));
  always #4 clock_i = ~clock_i;
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    serial_host_i.xfer({1'b0, a, d}, 16, rd);
    repeat (8) @(posedge clock_i);
  endtask
  // read carries all-ones data, which must not be written
  task automatic rb(input logic [6:0] a, input logic [7:0] exp);
    serial_host_i.xfer({1'b1, a, 8'hff}, 16, rd);
    check(rd, exp);
  endtask
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      stop_test();
    end
  end
  initial
  begin
    logic [27:0] r;
    repeat (12) @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    check(drive, CURR_3M5);
    check({lanes, bits}, 7'h50);
    check({lane_en, dco_en, fr_en}, 3'h7);
    check(out_data, 14'h0000);
    rb(ADDR_TP_LOW, 8'h00);
    $display("reset values done");
    for (int i = 0; i < 8; i++)
    begin
      r = rows[i];
      wr(ADDR_OUT, r[27:20]);
      check({cur_sel, term, off, mode}, r[27:20]);
      check(drive, r[17:8]);
      check(cur_ok, r[17:8] != 10'h000);
      check({lanes, bits}, r[6:0]);
      check(mode_ok, r[6:0] != 7'h00);
      check({lane_en, dco_en, fr_en}, {3{~r[23]}});
      rb(ADDR_OUT, r[27:20]);
    end
    $display("output mode table done");
    @(posedge clock_i);
    sample_i    <= 12'h5a3;
    twos_comp_i <= 1'b1;
    randomize_i <= 1'b1;
    wr(ADDR_TP_LOW, 8'ha5);
    wr(ADDR_TP_HIGH, 8'hff);
    check(tp_en, 1'b1);
    check(out_data, 14'h3fa5);
    rb(ADDR_TP_HIGH, 8'hbf);
    rb(ADDR_TP_LOW, 8'ha5);
    wr(ADDR_TP_HIGH, 8'h3f);
    check(tp_en, 1'b0);
    check(out_data, 14'h0974);
    $display("test pattern done");
    wr(7'h05, 8'hff);
    rb(7'h05, 8'h00);
    rb(ADDR_OUT, 8'hf7);
    $display("unmapped address done");
    wr(ADDR_RESET, 8'h80);
    rb(ADDR_OUT, 8'h00);
    rb(ADDR_TP_HIGH, 8'h00);
    rb(ADDR_TP_LOW, 8'h00);
    check(drive, CURR_3M5);
    $display("software reset done");
    wr(ADDR_OUT, 8'h4a);
    // a frame cut after twelve edges must leave the register alone
    serial_host_i.xfer({1'b0, ADDR_OUT, 8'h21}, 12, rd);
    rb(ADDR_OUT, 8'h4a);
    // edges past the sixteenth are ignored
    serial_host_i.xfer({1'b0, ADDR_TP_LOW, 8'h3c}, 20, rd);
    repeat (8) @(posedge clock_i);
    rb(ADDR_TP_LOW, 8'h3c);
    $display("frame length done");
    @(posedge clock_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    check({cur_sel, term, off, mode}, 8'h00);
    check({lane_en, dco_en, fr_en}, 3'h7);
    check(drive, CURR_3M5);
    rb(ADDR_TP_LOW, 8'h00);
    $display("mid-run reset done");
    stop_test();
  end
endmodule
